// ==== port_io_crossbar_config.sv ====
// Notes on behaviour
// - pullup disable off: pullups on except analog
// - crossbar control low six bits zero
// - config bit n governs port1 pin n
// - analog pin: no pullup, no receiver
// - analog select one means digital pin
// - output type: 0 open-drain, 1 push-pull
// - output type still drives analog pins
// - drive strength: 0 low, 1 high
// - port2 bit7 latch write, pin read
// - port2 bits six to zero read zero
module port_io_crossbar_config
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  input wire logic [7:0] p1_out_i,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_pin_o,
  output logic [7:0] p1_oe_o,
  output logic [7:0] p1_pullup_en_o,
  output logic [7:0] p1_rx_en_o,
  output logic [7:0] p1_high_drive_o,
  output logic [7:0] p1_in_o,
  input wire logic p2_pin_i,
  output logic p2_pin_o,
  output logic p2_oe_o,
  output logic p2_pullup_en_o
);

  // ****************************************
  // register bus
  // ****************************************
  sfr_bus_if bus ();
  assign bus.wr = sfr_wr_i;
  assign bus.rd = sfr_rd_i;
  assign bus.addr = sfr_addr_i;
  assign bus.wdata = sfr_wdata_i;

  logic [7:0] drive_q;
  logic [7:0] p2_q;
  logic [7:0] otype_q;
  logic [7:0] xbar_q;
  logic [7:0] analog_q;
  logic [4:0] sel;
  logic [7:0] p1_sync_a;
  logic [7:0] p1_sync_b;
  logic p2_sync_a;
  logic p2_sync_b;

  sfr_reg8 #(.ADDR(port_cfg_pkg::ADDR_P1_DRIVE), .RST(port_cfg_pkg::P1_DRIVE_RST),
    .MASK(8'hFF)) u_drive
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(bus.wr),
    .addr_i(bus.addr),
    .wdata_i(bus.wdata),
    .sel_o(sel[0]),
    .value_o(drive_q)
  );

  sfr_reg8 #(.ADDR(port_cfg_pkg::ADDR_P2_DATA), .RST(port_cfg_pkg::P2_DATA_RST),
    .MASK(port_cfg_pkg::P2_DATA_MASK)) u_p2
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(bus.wr),
    .addr_i(bus.addr),
    .wdata_i(bus.wdata),
    .sel_o(sel[1]),
    .value_o(p2_q)
  );

  sfr_reg8 #(.ADDR(port_cfg_pkg::ADDR_P1_OTYPE), .RST(port_cfg_pkg::P1_OTYPE_RST),
    .MASK(8'hFF)) u_otype
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(bus.wr),
    .addr_i(bus.addr),
    .wdata_i(bus.wdata),
    .sel_o(sel[2]),
    .value_o(otype_q)
  );

  sfr_reg8 #(.ADDR(port_cfg_pkg::ADDR_XBAR_CTL), .RST(port_cfg_pkg::XBAR_CTL_RST),
    .MASK(port_cfg_pkg::XBAR_CTL_MASK)) u_xbar
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(bus.wr),
    .addr_i(bus.addr),
    .wdata_i(bus.wdata),
    .sel_o(sel[3]),
    .value_o(xbar_q)
  );

  sfr_reg8 #(.ADDR(port_cfg_pkg::ADDR_P1_ANALOG), .RST(port_cfg_pkg::P1_ANALOG_RST),
    .MASK(8'hFF)) u_analog
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(bus.wr),
    .addr_i(bus.addr),
    .wdata_i(bus.wdata),
    .sel_o(sel[4]),
    .value_o(analog_q)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      p1_sync_a <= 8'h00;
      p1_sync_b <= 8'h00;
      p2_sync_a <= 1'b0;
      p2_sync_b <= 1'b0;
    end
    else
    begin
      p1_sync_a <= p1_pin_i;
      p1_sync_b <= p1_sync_a;
      p2_sync_a <= p2_pin_i;
      p2_sync_b <= p2_sync_a;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // unmapped addresses answer zero with hit low
  always_comb
  begin
    bus.rdata = 8'h00;
    unique case (1'b1)
      sel[0]: bus.rdata = drive_q;
      sel[1]: bus.rdata = {p2_sync_b, 7'h00};
      sel[2]: bus.rdata = otype_q;
      sel[3]: bus.rdata = xbar_q;
      sel[4]: bus.rdata = analog_q;
      default: bus.rdata = 8'h00;
    endcase
  end
  assign bus.hit = |sel;
  assign sfr_rdata_o = bus.rdata;
  assign sfr_hit_o = bus.hit;

  // ****************************************
  // pad control
  // ****************************************
  logic xbar_en;
  logic pull_dis;
  assign xbar_en = xbar_q[port_cfg_pkg::XBAR_EN_BIT];
  assign pull_dis = xbar_q[port_cfg_pkg::PULLUP_DIS_BIT];

  for (genvar n = 0; n < 8; n++)
  begin : g_p1
    // bit n low selects analog on pin n
    logic low_drive;
    assign low_drive = ~p1_out_i[n];
    // open-drain only ever pulls low; driver stays live in analog mode
    assign p1_oe_o[n] = xbar_en & (otype_q[n] | low_drive);
    assign p1_pin_o[n] = otype_q[n] ? p1_out_i[n] : 1'b0;
    assign p1_pullup_en_o[n] = ~pull_dis & analog_q[n];
    assign p1_rx_en_o[n] = analog_q[n];
    assign p1_high_drive_o[n] = drive_q[n];
    assign p1_in_o[n] = analog_q[n] & p1_sync_b[n];
  end

  // port 2 pin has no mode registers here, so it runs open-drain digital
  assign p2_pin_o = 1'b0;
  assign p2_oe_o = xbar_en & ~p2_q[port_cfg_pkg::P2_DATA_BIT];
  assign p2_pullup_en_o = ~pull_dis;

  // ****************************************
  // checks
  // ****************************************
  no_drive_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !xbar_en |-> (p1_oe_o == 8'h00) && !p2_oe_o)
  else $error("pin driven with crossbar off");

  pullup_dis_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pull_dis |-> (p1_pullup_en_o == 8'h00) && !p2_pullup_en_o)
  else $error("pullup on while disabled");

  analog_pull_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ((p1_pullup_en_o | p1_rx_en_o) & ~analog_q) == 8'h00)
  else $error("analog pin has pullup or receiver");

  digital_rx_a: assert property (@(posedge clock_i) disable iff (rst_i)
    p1_rx_en_o == analog_q)
  else $error("digital pin receiver off");

  pushpull_a: assert property (@(posedge clock_i) disable iff (rst_i)
    xbar_en |-> ((otype_q & ~p1_oe_o) == 8'h00))
  else $error("push-pull pin not driven");

  otype_analog_a: assert property (@(posedge clock_i) disable iff (rst_i)
    xbar_en && (otype_q != 8'h00) |-> ((p1_oe_o & otype_q) == otype_q))
  else $error("driver dropped for analog pin");

  drive_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bus.wr && sel[0] |=> p1_high_drive_o == $past(bus.wdata))
  else $error("drive strength not updated");

  xbar_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
    sel[3] |-> sfr_rdata_o[5:0] == 6'h00)
  else $error("crossbar low bits nonzero");

  p2_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    sel[1] |-> sfr_rdata_o[6:0] == 7'h00 && sfr_rdata_o[7] == p2_sync_b)
  else $error("port2 read wrong");

  // analog select resets to all digital, so every receiver is live after reset
  reset_val_a: assert property (@(posedge clock_i)
    $past(rst_i) |-> p2_q == port_cfg_pkg::P2_DATA_RST && otype_q == port_cfg_pkg::P1_OTYPE_RST
      && drive_q == port_cfg_pkg::P1_DRIVE_RST && xbar_q == port_cfg_pkg::XBAR_CTL_RST
      && analog_q == port_cfg_pkg::P1_ANALOG_RST)
  else $error("reset value wrong");

  in_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (p1_in_o & ~analog_q) == 8'h00)
  else $error("analog pin passes input");

  open_drain_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (p1_pin_o & ~otype_q) == 8'h00)
  else $error("open-drain pin driven high");

  p2_latch_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bus.wr && sel[1] |=> p2_q[port_cfg_pkg::P2_DATA_BIT] == $past(bus.wdata[7]))
  else $error("port2 latch not written");

  p2_low_bits_a: assert property (@(posedge clock_i) disable iff (rst_i)
    p2_q[6:0] == 7'h00)
  else $error("port2 low bits stored");

  xbar_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !(bus.wr && sel[3]) |=> $stable(xbar_q))
  else $error("crossbar control changed unwritten");

  p2_od_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !p2_pin_o)
  else $error("port2 pin driven high");

  p2_low_c: cover property (@(posedge clock_i) disable iff (rst_i) p2_oe_o);
  xbar_on_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(xbar_en));
  analog_c: cover property (@(posedge clock_i) disable iff (rst_i) analog_q != 8'hFF);
  pull_off_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(pull_dis));
  pushpull_c: cover property (@(posedge clock_i) disable iff (rst_i) (p1_oe_o & otype_q) != 8'h00);
endmodule : port_io_crossbar_config

// ==== port_cfg_pkg.sv ====
package port_cfg_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_P1_DRIVE = 8'h9B;
  localparam logic [7:0] ADDR_P2_DATA = 8'hA0;
  localparam logic [7:0] ADDR_P1_OTYPE = 8'hA5;
  localparam logic [7:0] ADDR_XBAR_CTL = 8'hE3;
  localparam logic [7:0] ADDR_P1_ANALOG = 8'hF2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PULLUP_DIS_BIT = 7;
  localparam int XBAR_EN_BIT = 6;
  localparam int P2_DATA_BIT = 7;

  // ****************************************
  // reset values and write masks
  // ****************************************
  localparam logic [7:0] P1_DRIVE_RST = 8'h00;
  localparam logic [7:0] P2_DATA_RST = 8'h80;
  localparam logic [7:0] P1_OTYPE_RST = 8'h00;
  localparam logic [7:0] XBAR_CTL_RST = 8'h00;
  localparam logic [7:0] P1_ANALOG_RST = 8'hFF;
  localparam logic [7:0] XBAR_CTL_MASK = 8'hC0;
  localparam logic [7:0] P2_DATA_MASK = 8'h80;

endpackage : port_cfg_pkg

// ==== sfr_bus_if.sv ====
interface sfr_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport master
  (
    output wr,
    output rd,
    output addr,
    output wdata,
    input rdata,
    input hit
  );

  modport slave
  (
    input wr,
    input rd,
    input addr,
    input wdata,
    output rdata,
    output hit
  );
endinterface : sfr_bus_if

// ==== sfr_reg8.sv ====
module sfr_reg8
#(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic sel_o,
  output logic [7:0] value_o
);
  logic [7:0] value_q;
  logic [7:0] value_d;

  assign sel_o = (addr_i == ADDR);
  assign value_o = value_q;

  // masked bits hold zero, writes to them dropped
  always_comb
  begin
    value_d = value_q;
    if (wr_i && sel_o)
    begin
      value_d = wdata_i & MASK;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      value_q <= RST;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assert property (@(posedge clock_i) disable iff (rst_i)
    (value_q & ~MASK) == 8'h00)
  else $error("masked register bits nonzero");
endmodule : sfr_reg8

// ==== pin_board.sv ====
module pin_board
(
  input wire logic clock_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pull_i,
  input wire logic p2_drv_i,
  input wire logic p2_oe_i,
  input wire logic p2_pull_i,
  output logic [7:0] level_o,
  output logic p2_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // an undriven pin with no pullup wanders, so nothing reads it as a clean level
  logic wander_q = 1'b0;
  always @(posedge clock_i) wander_q <= ~wander_q;
  assign level_o = (oe_i & drv_i) | (~oe_i & (pull_i | {8{wander_q}}));
  assign p2_level_o = p2_oe_i ? p2_drv_i : (p2_pull_i | wander_q);
endmodule : pin_board

// ==== test_port_io_crossbar_config.sv ====
module test_port_io_crossbar_config;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] kind; logic [7:0] val;} note_t;
  note_t notes[$];
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, p1_out = 8'h00;
  logic [7:0] rdata, pin, drv, oe, pull, rx, hd, p1_in, seen;
  logic [7:0] a, t, d, x, o, l, ev, ep;
  logic hit, p2_pin, p2_o, p2_oe, p2_pull;
  int err_count = 0;
  int total_checks = 0;
  port_io_crossbar_config dut
  (
    .clock_i(clock_i), .rst_i(rst_i),
    .sfr_wr_i(wr_en), .sfr_rd_i(rd_en),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .p1_out_i(p1_out), .p1_pin_i(pin),
    .p1_pin_o(drv), .p1_oe_o(oe),
    .p1_pullup_en_o(pull), .p1_rx_en_o(rx),
    .p1_high_drive_o(hd), .p1_in_o(p1_in),
    .p2_pin_i(p2_pin), .p2_pin_o(p2_o),
    .p2_oe_o(p2_oe), .p2_pullup_en_o(p2_pull)
  );
  pin_board board
  (
    .clock_i(clock_i), .drv_i(drv), .oe_i(oe), .pull_i(pull),
    .p2_drv_i(p2_o), .p2_oe_i(p2_oe), .p2_pull_i(p2_pull),
    .level_o(pin), .p2_level_o(p2_pin)
  );
  initial forever #10 clock_i = ~clock_i;
  // ****
  // tasks
  // ****
  task automatic check_value(input logic [7:0] s, input logic [7:0] w);
    total_checks++;
    if (s !== w)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, w);
    end
  endtask : check_value
  task automatic wr(input logic [7:0] adr, input logic [7:0] val);
    @(posedge clock_i);
    addr <= adr;
    wdata <= val;
    wr_en <= 1'b1;
    @(posedge clock_i);
    wr_en <= 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] adr, input logic [2:0] k, input logic [7:0] v);
    @(posedge clock_i);
    addr <= adr;
    rd_en <= 1'b1;
    notes.push_back('{k, v});
    @(posedge clock_i);
    rd_en <= 1'b0;
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(negedge clock_i)
  begin
    if (rd_en && notes.size() > 0)
    begin
      case (notes[0].kind)
        3'h0: seen = rdata;
        3'h1: seen = oe;
        3'h2: seen = pull;
        3'h3: seen = rx;
        3'h4: seen = hd;
        3'h5: seen = p1_in;
        3'h6: seen = drv & oe;
        default: seen = {4'h0, hit, p2_oe, p2_pull, p2_o};
      endcase
      check_value(seen, notes[0].val);
      void'(notes.pop_front());
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    void'($urandom(32'h1E75));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    // pin synchroniser needs two edges
    repeat (3) @(posedge clock_i);
    chk(8'h9B, 0, 8'h00);
    chk(8'hA0, 0, 8'h80);
    chk(8'hA5, 0, 8'h00);
    chk(8'hE3, 0, 8'h00);
    chk(8'hF2, 0, 8'hFF);
    chk(8'h3C, 7, 8'h02);
    chk(8'h3C, 1, 8'h00);
    $display("reset test done");
    wr(8'hE3, 8'h3F);
    chk(8'hE3, 0, 8'h00);
    wr(8'hA0, 8'h7F);
    chk(8'hA0, 0, 8'h80);
    wr(8'hE3, 8'h40);
    chk(8'hA0, 7, 8'h0E);
    chk(8'hA0, 0, 8'h00);
    wr(8'hA0, 8'h80);
    repeat (2) @(posedge clock_i);
    chk(8'hA0, 0, 8'h80);
    wr(8'hE3, 8'h80);
    chk(8'hA0, 7, 8'h08);
    $display("port2 test done");
    for (int i = 0; i < 8; i++)
    begin
      a = $urandom;
      t = $urandom;
      d = $urandom;
      x = $urandom;
      o = $urandom;
      l = $urandom;
      p1_out <= o;
      wr(8'hF2, a);
      wr(8'hA5, t);
      wr(8'h9B, d);
      wr(8'hE3, x);
      wr(8'hA0, l);
      ev = x[6] ? (t | ~o) : 8'h00;
      ep = t & o & ev;
      chk(8'hF2, 0, a);
      chk(8'hA5, 0, t);
      chk(8'h9B, 0, d);
      chk(8'hE3, 0, x & 8'hC0);
      chk(8'hA0, 7, {4'h0, 1'b1, x[6] & ~l[7], ~x[7], 1'b0});
      chk(8'hF2, 1, ev);
      chk(8'hF2, 6, ep);
      chk(8'hF2, 2, x[7] ? 8'h00 : a);
      chk(8'hF2, 3, a);
      chk(8'hF2, 4, d);
      if (!x[7])
        chk(8'hF2, 5, a & (~ev | ep));
    end
    $display("port1 test done");
    give_verdict();
  end
  // run needs about 310 cycles, so 5000 is a hang
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule : test_port_io_crossbar_config
